//--- hdl/i2c_slave_pkg.sv
/*
 * Constants and types shared by the I2C register access slave.
 * Assumes a single 100 MHz system clock and a bus master up to 400 kHz.
 */
package i2c_slave_pkg;

    // ----------------------------------------------------------------
    // Bus addressing
    // ----------------------------------------------------------------
    localparam logic [6:0] BUS_DEVICE_ADDRESS = 7'h36;
    localparam logic [7:0] WRITE_TOP = 8'h4F;
    localparam logic [7:0] PTR_TOP = 8'hFF;
    localparam logic [7:0] READ_FILL = 8'hFF;
    localparam int WORD_COUNT = 40;

    // ----------------------------------------------------------------
    // Byte framing
    // ----------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic LINE_IDLE = 1'b1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SPIKE_NS = 20;
    localparam int SPIKE_CYCLES =
        (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Protocol states
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_WR_BYTE = 7'h08,
        ST_WR_ACK = 7'h10,
        ST_RD_BYTE = 7'h20,
        ST_RD_ACK = 7'h40
    } state_t;

endpackage

//--- hdl/bit_sync.sv
/*
 * Two flip-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level; no relation between bits is kept.
 */
`timescale 1ns/1ns
module bit_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ----------------------------------------------------------------
    // Stages
    // ----------------------------------------------------------------
    // Resets to all ones so an idle bus does not look like a START.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule

//--- hdl/i2c_register_access_slave.sv
/*
 * I2C slave front end giving an external master byte access to a
 * register map, with auto-increment, write filtering and read fill.
 * Assumes the register store sits on clk, answers rd_data for rd_addr
 * within one cycle, and commits wr_data on a one-cycle wr_en pulse.
 */
`timescale 1ns/1ns
module i2c_register_access_slave
    import i2c_slave_pkg::*;
#(
    parameter logic [WORD_COUNT-1:0] WORD_WRITABLE = '1,
    parameter int FILTER_CYCLES = SPIKE_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [15:0] wr_data,
    output logic wr_drop,
    output logic busy
);

    localparam int FW = (FILTER_CYCLES > 1) ? $clog2(FILTER_CYCLES) : 1;
    localparam logic [FW-1:0] FILTER_LAST = FW'(FILTER_CYCLES - 1);
    localparam logic [FW-1:0] FILTER_ZERO = '0;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [1:0] sync_w;
    logic flt_q [2];
    logic [FW-1:0] stab_q [2];
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_now;
    logic sda_now;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] rx_byte;
    logic rw_q;
    logic addr_hit;
    logic byte_end;
    logic lsb_rise;

    logic [7:0] ptr_q;
    logic over_q;
    logic expect_ptr_q;
    logic is_ptr_q;
    logic [7:0] cur_addr_q;
    logic cur_over_q;
    logic [7:0] data_q;
    logic [7:0] msb_q;
    logic msb_valid_q;

    logic [7:0] tx_q;
    logic [7:0] tx_first;
    logic master_ack_q;
    logic oe_q;
    logic wr_en_q;
    logic [7:0] wr_addr_q;
    logic [15:0] wr_data_q;
    logic wr_drop_q;
    logic busy_q;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic receiving(input state_t s);
        receiving = (s == ST_ADDR) || (s == ST_WR_BYTE);
    endfunction

    function automatic logic in_byte(input state_t s);
        in_byte = receiving(s) || (s == ST_RD_BYTE);
    endfunction

    function automatic logic word_writable(input logic [7:0] a);
        word_writable = WORD_WRITABLE[int'(a[7:1])];
    endfunction

    // ----------------------------------------------------------------
    // Input conditioning
    // ----------------------------------------------------------------
    // Both lines see the same filter delay, so the order of SDA and
    // SCL edges, which START and STOP depend on, is kept intact.
    bit_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d({scl_i, sda_i}),
        .q(sync_w)
    );

    for (genvar g = 0; g < 2; g++) begin : g_filt
        always_ff @(posedge clk) begin
            if (!rstn) begin
                flt_q[g] <= LINE_IDLE;
                stab_q[g] <= FILTER_ZERO;
            end else if (sync_w[g] == flt_q[g]) begin
                stab_q[g] <= FILTER_ZERO;
            end else if (stab_q[g] == FILTER_LAST) begin
                flt_q[g] <= sync_w[g];
                stab_q[g] <= FILTER_ZERO;
            end else begin
                stab_q[g] <= stab_q[g] + 1'b1;
            end
        end
    end

    assign scl_now = flt_q[1];
    assign sda_now = flt_q[0];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_prev_q <= LINE_IDLE;
            sda_prev_q <= LINE_IDLE;
        end else begin
            scl_prev_q <= scl_now;
            sda_prev_q <= sda_now;
        end
    end

    // Oversampling at the system clock tracks any SCL up to the top
    // rate, so no speed setting exists.
    assign scl_rise = scl_now & ~scl_prev_q;
    assign scl_fall = ~scl_now & scl_prev_q;
    assign start_ev = scl_now & scl_prev_q & sda_prev_q & ~sda_now;
    assign stop_ev = scl_now & scl_prev_q & ~sda_prev_q & sda_now;

    assign rx_byte = {shift_q[6:0], sda_now};
    assign addr_hit = (shift_q[7:1] == BUS_DEVICE_ADDRESS);
    assign byte_end = scl_fall && (cnt_q == BYTE_BITS);
    assign lsb_rise = scl_rise && (cnt_q == LAST_BIT);
    assign tx_first = over_q ? READ_FILL : rd_data;

    // ----------------------------------------------------------------
    // Protocol state
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
        end else if (start_ev) begin
            state_q <= ST_ADDR;
        end else if (stop_ev) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_ADDR: begin
                    if (byte_end) begin
                        state_q <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        state_q <= rw_q ? ST_RD_BYTE : ST_WR_BYTE;
                    end
                end
                ST_WR_BYTE: begin
                    if (byte_end) begin
                        state_q <= ST_WR_ACK;
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        state_q <= ST_WR_BYTE;
                    end
                end
                ST_RD_BYTE: begin
                    if (byte_end) begin
                        state_q <= ST_RD_ACK;
                    end
                end
                ST_RD_ACK: begin
                    if (scl_fall) begin
                        state_q <= master_ack_q ? ST_RD_BYTE : ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Bit counting and shifting
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q <= CNT_RESET;
        end else if (start_ev || stop_ev || !in_byte(state_q)) begin
            cnt_q <= CNT_RESET;
        end else if (scl_rise) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            shift_q <= PTR_RESET;
        end else if (scl_rise && receiving(state_q)) begin
            shift_q <= rx_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rw_q <= 1'b0;
        end else if (state_q == ST_ADDR && byte_end) begin
            rw_q <= shift_q[0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            master_ack_q <= 1'b0;
        end else if (state_q == ST_RD_ACK && scl_rise) begin
            master_ack_q <= ~sda_now;
        end
    end

    // ----------------------------------------------------------------
    // Byte pointer
    // ----------------------------------------------------------------
    // The pointer survives a repeated START, which is how the write
    // portion of a read hands its start address to the read portion.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ptr_q <= PTR_RESET;
            over_q <= 1'b0;
            expect_ptr_q <= 1'b0;
            is_ptr_q <= 1'b0;
            cur_addr_q <= PTR_RESET;
            cur_over_q <= 1'b0;
            data_q <= PTR_RESET;
        end else if (start_ev || stop_ev) begin
            expect_ptr_q <= 1'b0;
        end else if (state_q == ST_ADDR_ACK && scl_fall && !rw_q) begin
            expect_ptr_q <= 1'b1;
        end else if (lsb_rise && state_q == ST_WR_BYTE && expect_ptr_q) begin
            ptr_q <= rx_byte;
            over_q <= 1'b0;
            expect_ptr_q <= 1'b0;
            is_ptr_q <= 1'b1;
        end else if (lsb_rise && in_byte(state_q) && state_q != ST_ADDR) begin
            if (state_q == ST_WR_BYTE) begin
                cur_addr_q <= ptr_q;
                cur_over_q <= over_q;
                data_q <= rx_byte;
                is_ptr_q <= 1'b0;
            end
            if (ptr_q == PTR_TOP) begin
                over_q <= 1'b1;
            end else if (!over_q) begin
                ptr_q <= ptr_q + 1'b1;
            end
        end
    end

    assign rd_addr = ptr_q;

    // ----------------------------------------------------------------
    // Write pairing and commit
    // ----------------------------------------------------------------
    // A byte is only acted on at the close of its acknowledge clock,
    // so a START or STOP inside the byte leaves no trace.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            msb_q <= PTR_RESET;
            msb_valid_q <= 1'b0;
            wr_en_q <= 1'b0;
            wr_drop_q <= 1'b0;
            wr_addr_q <= PTR_RESET;
            wr_data_q <= 16'h0000;
        end else begin
            wr_en_q <= 1'b0;
            wr_drop_q <= 1'b0;
            if (start_ev || stop_ev) begin
                msb_valid_q <= 1'b0;
            end else if (state_q == ST_WR_ACK && scl_fall && !is_ptr_q) begin
                if (cur_over_q || cur_addr_q > WRITE_TOP) begin
                    msb_valid_q <= 1'b0;
                    wr_drop_q <= 1'b1;
                end else if (!cur_addr_q[0]) begin
                    msb_q <= data_q;
                    msb_valid_q <= 1'b1;
                end else begin
                    msb_valid_q <= 1'b0;
                    if (msb_valid_q && word_writable(cur_addr_q)) begin
                        wr_en_q <= 1'b1;
                        wr_addr_q <= {cur_addr_q[7:1], 1'b0};
                        wr_data_q <= {msb_q, data_q};
                    end else begin
                        wr_drop_q <= 1'b1;
                    end
                end
            end
        end
    end

    assign wr_en = wr_en_q;
    assign wr_addr = wr_addr_q;
    assign wr_data = wr_data_q;
    assign wr_drop = wr_drop_q;

    // ----------------------------------------------------------------
    // Transmit data
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_q <= READ_FILL;
        end else if (state_q == ST_ADDR_ACK && scl_fall && rw_q) begin
            tx_q <= tx_first;
        end else if (state_q == ST_RD_ACK && scl_fall && master_ack_q) begin
            tx_q <= tx_first;
        end
    end

    // ----------------------------------------------------------------
    // SDA drive
    // ----------------------------------------------------------------
    // The pin is open drain: only a low is ever driven, and SDA changes
    // only just after SCL falls, which gives the master its hold time.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            oe_q <= 1'b0;
        end else if (start_ev || stop_ev) begin
            oe_q <= 1'b0;
        end else if (scl_fall) begin
            case (state_q)
                ST_ADDR: begin
                    oe_q <= (cnt_q == BYTE_BITS) && addr_hit;
                end
                ST_ADDR_ACK: begin
                    oe_q <= rw_q && !tx_first[7];
                end
                ST_WR_BYTE: begin
                    oe_q <= (cnt_q == BYTE_BITS);
                end
                ST_WR_ACK: begin
                    oe_q <= 1'b0;
                end
                ST_RD_BYTE: begin
                    if (cnt_q == BYTE_BITS) begin
                        oe_q <= 1'b0;
                    end else begin
                        oe_q <= !tx_q[3'(LAST_BIT - cnt_q)];
                    end
                end
                ST_RD_ACK: begin
                    oe_q <= master_ack_q && !tx_first[7];
                end
                default: begin
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    assign sda_oe = oe_q;
    assign sda_o = 1'b0;

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_q != ST_IDLE);
        end
    end

    assign busy = busy_q;

endmodule

//--- verif/i2c_slave_sva.sv
/*
 * Concurrent checks on the ports of the I2C register access slave.
 * Assumes one clock domain, clk, with the synchronous reset rstn.
 */
`timescale 1ns/1ns
module i2c_slave_sva
    import i2c_slave_pkg::*;
#(
    parameter logic [WORD_COUNT-1:0] WORD_WRITABLE = '1,
    parameter int FILTER_CYCLES = SPIKE_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_drop,
    input wire logic busy
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_drive_low;
        sda_o == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("sda_o is not held low");
    property p_wr_pulse;
        wr_en |=> !wr_en;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("commit pulse longer than one cycle");
    property p_wr_even;
        wr_en |-> !wr_addr[0];
    endproperty
    a_wr_even: assert property (p_wr_even)
        else $error("commit at an odd address");
    property p_wr_range;
        wr_en |-> wr_addr < WRITE_TOP;
    endproperty
    a_wr_range: assert property (p_wr_range)
        else $error("commit above the writable top");
    property p_wr_writable;
        wr_en |-> WORD_WRITABLE[wr_addr[7:1]];
    endproperty
    a_wr_writable: assert property (p_wr_writable)
        else $error("commit to a read-only word");
    property p_wr_ptr;
        wr_en |-> rd_addr == wr_addr + 8'h02;
    endproperty
    a_wr_ptr: assert property (p_wr_ptr)
        else $error("pointer not two past the committed word");
    property p_oe_rise_low;
        $rose(sda_oe) |-> !scl_i;
    endproperty
    a_oe_rise_low: assert property (p_oe_rise_low)
        else $error("SDA pulled while SCL high");
    property p_oe_hold;
        $rose(sda_oe) |=> $stable(sda_oe) [*4];
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("SDA drive not held through the bit");
    property p_stop_idle;
        scl_i && $rose(sda_i) |-> ##[1:12] (!busy && !sda_oe);
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("no return to idle after STOP");
endmodule

//--- verif/i2c_master_model.sv
/*
 * Behavioural I2C bus master driving SCL and its share of SDA.
 * Assumes a pull-up on SDA, made by the bench from all drivers.
 */
`timescale 1ns/1ns
module i2c_master_model (
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    // ----------------------------------------------------------------
    // Bit timing
    // ----------------------------------------------------------------
    // The low phase is longer than the high one, so the slave's answer,
    // which lands some 50 ns after the fall, settles before the rise.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Line changes are non-blocking, as some of them land on a clock
    // edge and must not race the slave's sampling flops.
    task automatic bit_x(input logic b, output logic s);
        #20 sda_drv <= b;
        #60 scl <= 1'b1;
        s = sda;
        #45 scl <= 1'b0;
    endtask
    task automatic start;
        #20 sda_drv <= 1'b1;
        #60 scl <= 1'b1;
        #60 sda_drv <= 1'b0;
        #60 scl <= 1'b0;
    endtask
    task automatic stop;
        #20 sda_drv <= 1'b0;
        #60 scl <= 1'b1;
        #60 sda_drv <= 1'b1;
        #200;
    endtask
    task automatic wbits(input logic [7:0] d, input int n);
        logic s;
        for (int i = 7; i > 7 - n; i--) begin
            bit_x(d[i], s);
        end
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        wbits(d, 8);
        bit_x(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            d[i] = s;
        end
        bit_x(nack, s);
    endtask
endmodule

//--- verif/i2c_register_access_slave_tb_top.sv
/*
 * Self-checking bench for the I2C register access slave.
 * Assumes the master model and checker files are compiled first.
 */
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    errors++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module i2c_register_access_slave_tb_top
    import i2c_slave_pkg::*;
;
    // Word 1 (bytes 02 and 03) is read-only in this build.
    localparam logic [39:0] WW = 40'hFF_FFFF_FFFD;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] rd_data = 8'h00;
    wire scl, sda_m, sda;
    logic sda_o, sda_oe, wr_en, wr_drop, busy;
    logic [7:0] rd_addr, wr_addr;
    logic [15:0] wr_data;
    logic [7:0] mem [256];
    int errors = 0;
    int n_checks = 0;
    int drops = 0;

    always #5 clk = ~clk;
    assign sda = sda_m & ~(sda_oe & ~sda_o);
    always @(posedge clk) begin
        if (wr_drop) begin
            drops++;
        end
    end
    function automatic logic [7:0] ini(input logic [7:0] a);
        return a ^ 8'hA5;
    endfunction
    initial for (int i = 0; i < 256; i++) mem[i] = ini(8'(i));
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data[15:8];
            mem[wr_addr + 8'h01] <= wr_data[7:0];
        end
        rd_data <= mem[rd_addr];
    end

    i2c_master_model m (.scl(scl), .sda_drv(sda_m), .sda(sda));
    i2c_register_access_slave #(.WORD_WRITABLE(WW),
        .FILTER_CYCLES(SPIKE_CYCLES))
    DUT (.clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_drop(wr_drop), .busy(busy));

    // ----------------------------------------------------------------
    // Transactions
    // ----------------------------------------------------------------
    task automatic head(input logic [7:0] p);
        logic a;
        m.start();
        m.wbyte(8'h6C, a);
        `CHK("addr ack", 1'b1, a);
        m.wbyte(p, a);
        `CHK("ptr ack", 1'b1, a);
    endtask
    task automatic fin;
        m.stop();
        repeat (10) @(posedge clk);
        `CHK("busy", 1'b0, busy);
        `CHK("oe", 1'b0, sda_oe);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d [$]);
        logic a;
        head(p);
        foreach (d[i]) begin
            m.wbyte(d[i], a);
            `CHK("data ack", 1'b1, a);
        end
        fin();
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] e [$]);
        logic a;
        logic [7:0] v;
        head(p);
        m.start();
        m.wbyte(8'h6D, a);
        `CHK("read ack", 1'b1, a);
        foreach (e[i]) begin
            m.rbyte(i == e.size() - 1, v);
            `CHK("read byte", e[i], v);
        end
        fin();
    endtask
    task automatic probe(input logic [7:0] b, input logic exp);
        logic a;
        m.start();
        m.wbyte(b, a);
        `CHK("probe ack", exp, a);
        m.stop();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_probe;
        probe(8'h6D, 1'b1);
        probe(8'h6C, 1'b1);
        probe(8'h50, 1'b0);
        probe(8'h6E, 1'b0);
        $display("test probe done");
    endtask
    task automatic t_readonly;
        int d0;
        d0 = drops;
        wr(8'h02, '{8'h11, 8'h22, 8'h33, 8'h44});
        `CHK("drops", 1, drops - d0);
        `CHK("mem 02", ini(8'h02), mem[8'h02]);
        `CHK("mem 03", ini(8'h03), mem[8'h03]);
        `CHK("mem 04", 8'h33, mem[8'h04]);
        `CHK("mem 05", 8'h44, mem[8'h05]);
        $display("test readonly done");
    endtask
    task automatic t_pairs;
        int d0;
        d0 = drops;
        wr(8'h09, '{8'h77, 8'h88});
        `CHK("drops", 1, drops - d0);
        `CHK("mem 09", ini(8'h09), mem[8'h09]);
        `CHK("mem 0A", ini(8'h0A), mem[8'h0A]);
        wr(8'h08, '{8'hC1, 8'hC2, 8'hC3});
        `CHK("mem 08", 8'hC1, mem[8'h08]);
        `CHK("mem 09", 8'hC2, mem[8'h09]);
        `CHK("mem 0A", ini(8'h0A), mem[8'h0A]);
        $display("test pairs done");
    endtask
    task automatic t_top;
        int d0;
        d0 = drops;
        wr(8'h4E, '{8'hD1, 8'hD2, 8'hD3, 8'hD4});
        `CHK("drops", 2, drops - d0);
        `CHK("mem 4E", 8'hD1, mem[8'h4E]);
        `CHK("mem 4F", 8'hD2, mem[8'h4F]);
        `CHK("mem 50", ini(8'h50), mem[8'h50]);
        `CHK("mem 51", ini(8'h51), mem[8'h51]);
        $display("test top done");
    endtask
    task automatic t_abort;
        logic a;
        head(8'h10);
        m.wbyte(8'hE1, a);
        m.wbits(8'hE2, 4);
        fin();
        `CHK("mem 10", ini(8'h10), mem[8'h10]);
        `CHK("mem 11", ini(8'h11), mem[8'h11]);
        head(8'h12);
        m.wbyte(8'hF1, a);
        wr(8'h14, '{8'hF2, 8'hF3});
        `CHK("mem 12", ini(8'h12), mem[8'h12]);
        `CHK("mem 14", 8'hF2, mem[8'h14]);
        $display("test abort done");
    endtask
    task automatic t_read;
        wr(8'h04, '{8'h12, 8'h34, 8'h56, 8'h78});
        rd(8'h04, '{8'h12, 8'h34, 8'h56, 8'h78});
        rd(8'hFE, '{ini(8'hFE), ini(8'hFF), READ_FILL, READ_FILL});
        `CHK("ptr", PTR_TOP, rd_addr);
        $display("test read done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #400_000;
        errors++;
        $display("watchdog expired");
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_probe();
        t_readonly();
        t_pairs();
        t_top();
        t_abort();
        t_read();
        wrap_up();
    end
endmodule

bind i2c_register_access_slave i2c_slave_sva #(
    .WORD_WRITABLE(WORD_WRITABLE), .FILTER_CYCLES(FILTER_CYCLES)
) u_sva (.clk(clk), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_drop(wr_drop), .busy(busy));
